// File: design/swt_pkg.sv
// Package of register map, field layout and timing constants for the wake-up timer
package swt_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] SWT_ADDR_RELOAD = 8'h86;
  localparam logic [7:0] SWT_ADDR_CTRL = 8'h8F;
  localparam logic [7:0] SWT_ADDR_EVT_STATUS = 8'h90;
  localparam logic [7:0] SWT_ADDR_EVT_MASK = 8'h91;
  localparam logic [7:0] SWT_ADDR_INT_EN = 8'h92;
  localparam logic [7:0] SWT_ADDR_COUNT = 8'h93;
  localparam logic [7:0] SWT_ADDR_STATE = 8'h94;

  // Control register fields
  localparam int SWT_CTRL_FLAG_BIT = 4;
  localparam int SWT_CTRL_RUN_BIT = 3;
  localparam int SWT_CTRL_PS_MSB = 2;
  localparam int SWT_CTRL_PS_LSB = 0;

  // Event status and mask layout
  localparam int SWT_EVT_NUM = 2;
  localparam int SWT_EVT_OVERFLOW = 0;
  localparam int SWT_EVT_UNSTABLE_START = 1;

  // Interrupt enable and state register fields
  localparam int SWT_INTEN_WAKE_BIT = 0;
  localparam int SWT_STATE_STABLE_BIT = 0;
  localparam int SWT_STATE_RUN_BIT = 1;

  // Reset values
  localparam logic [7:0] SWT_RELOAD_RST = 8'h00;
  localparam logic [7:0] SWT_CTRL_RST = 8'h00;
  localparam logic [7:0] SWT_COUNT_RST = 8'h00;
  localparam logic [2:0] SWT_PS_RST = 3'h0;

  // Counter rollover point
  localparam logic [7:0] SWT_COUNT_TOP = 8'hFF;

  // Prescale division widths: divide by 2**shift
  localparam int SWT_PS_WIDTH = 11;
  localparam logic [3:0] SWT_SHIFT_1 = 4'h0;
  localparam logic [3:0] SWT_SHIFT_4 = 4'h2;
  localparam logic [3:0] SWT_SHIFT_16 = 4'h4;
  localparam logic [3:0] SWT_SHIFT_64 = 4'h6;
  localparam logic [3:0] SWT_SHIFT_256 = 4'h8;
  localparam logic [3:0] SWT_SHIFT_512 = 4'h9;
  localparam logic [3:0] SWT_SHIFT_1024 = 4'hA;
  localparam logic [3:0] SWT_SHIFT_2048 = 4'hB;

  // Timing: system clock and slow oscillator
  localparam int SWT_SYS_FREQ_KHZ = 125000;
  localparam int SWT_LIRC_FREQ_KHZ = 10;
  localparam int SWT_SYNC_STAGES = 2;

endpackage

// File: design/swt_sync.sv
// Two-flop synchroniser for a level arriving from outside the clock domain
`timescale 1ns/1ns
module swt_sync
  import swt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Asynchronous level in, synchronised level out
  input wire logic asyncIn,
  output logic syncOut
);

  logic meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule // swt_sync

// File: design/swt_prescaler.sv
// Prescaler turning slow oscillator ticks into counter step pulses
`timescale 1ns/1ns
module swt_prescaler
  import swt_pkg::*;
#(
  parameter int PS_WIDTH = SWT_PS_WIDTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Tick from the slow oscillator, clear and division select
  input wire logic tickIn,
  input wire logic clear,
  input wire logic [2:0] divSel,
  // One-cycle step enable
  output logic stepOut
);

  logic [PS_WIDTH-1:0] div_q;
  logic [PS_WIDTH-1:0] div_d;
  logic [3:0] shiftAmt;
  logic [PS_WIDTH-1:0] lastCount;
  logic atLast;

  // Division table from the 3-bit select
  always_comb begin
    case (divSel)
      3'h0: shiftAmt = SWT_SHIFT_1;
      3'h1: shiftAmt = SWT_SHIFT_4;
      3'h2: shiftAmt = SWT_SHIFT_16;
      3'h3: shiftAmt = SWT_SHIFT_64;
      3'h4: shiftAmt = SWT_SHIFT_256;
      3'h5: shiftAmt = SWT_SHIFT_512;
      3'h6: shiftAmt = SWT_SHIFT_1024;
      default: shiftAmt = SWT_SHIFT_2048;
    endcase
  end

  // Terminal count and next value
  assign lastCount = PS_WIDTH'((1 << shiftAmt) - 1);
  assign atLast = (div_q >= lastCount);
  assign div_d = clear ? '0 : (tickIn ? (atLast ? '0 : div_q + 1'b1) : div_q);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_q <= '0;
      stepOut <= 1'b0;
    end else begin
      div_q <= div_d;
      stepOut <= tickIn && atLast && !clear;
    end
  end

endmodule // swt_prescaler

// File: design/swt_top.sv
// Self wake-up timer: register port, auto-reload counter and interrupt logic
`timescale 1ns/1ns
module swt_top
  import swt_pkg::*;
#(
  parameter int CNT_WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [7:0] rdData,
  // Slow oscillator pins
  input wire logic lircClk,
  input wire logic lircStable,
  // Power management and global enable
  input wire logic lowPowerMode,
  input wire logic globalIntEnable,
  output logic lircKeepOn,
  output logic wakeupEvent,
  // Interrupts
  output logic wakeupIrqReq,
  output logic irq
);

  // Synchronised pins and edge detection
  logic lircSync;
  logic stableSync;
  logic lircLast_q;
  logic lircTick;

  // Register state
  logic [7:0] reload_q;
  logic overflowFlag_q;
  logic overflowFlag_d;
  logic run_q;
  logic [2:0] prescale_q;
  logic [SWT_EVT_NUM-1:0] evtStatus_q;
  logic [SWT_EVT_NUM-1:0] evtStatus_d;
  logic [SWT_EVT_NUM-1:0] evtMask_q;
  logic wakeIntEn_q;
  logic [CNT_WIDTH-1:0] count_q;
  logic [CNT_WIDTH-1:0] count_d;
  logic [7:0] rdData_q;
  logic wakeupEvent_q;
  logic run_d;
  logic [2:0] prescale_d;
  logic [7:0] reload_d;
  logic [SWT_EVT_NUM-1:0] evtMask_d;
  logic wakeIntEn_d;

  // Decode and datapath wires
  logic selReload;
  logic selCtrl;
  logic selStatus;
  logic selMask;
  logic selIntEn;
  logic selCount;
  logic selState;
  logic wrReload;
  logic wrCtrl;
  logic wrStatus;
  logic wrMask;
  logic wrIntEn;
  logic startRun;
  logic step;
  logic rollover;
  logic [SWT_EVT_NUM-1:0] evtSet;
  logic [SWT_EVT_NUM-1:0] evtClr;
  logic [7:0] ctrlView;
  logic [7:0] stateView;
  logic [7:0] rdMux;

  // Oscillator pin and its stable indication enter through two flops
  swt_sync uLircSync (
    .clk(clk),
    .rstn(rstn),
    .asyncIn(lircClk),
    .syncOut(lircSync)
  );

  swt_sync uStableSync (
    .clk(clk),
    .rstn(rstn),
    .asyncIn(lircStable),
    .syncOut(stableSync)
  );

  // Edge history of the synchronised oscillator
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lircLast_q <= 1'b0;
    end else begin
      lircLast_q <= lircSync;
    end
  end

  // One tick per oscillator rising edge; needs clk above twice its rate
  assign lircTick = lircSync && !lircLast_q;

  // Prescaler cleared while halted so a start begins a full period
  swt_prescaler #(
    .PS_WIDTH(SWT_PS_WIDTH)
  ) uPrescaler (
    .clk(clk),
    .rstn(rstn),
    .tickIn(lircTick),
    .clear(!run_q),
    .divSel(prescale_q),
    .stepOut(step)
  );

  // Address decode
  assign selReload = (addr == SWT_ADDR_RELOAD);
  assign selCtrl = (addr == SWT_ADDR_CTRL);
  assign selStatus = (addr == SWT_ADDR_EVT_STATUS);
  assign selMask = (addr == SWT_ADDR_EVT_MASK);
  assign selIntEn = (addr == SWT_ADDR_INT_EN);
  assign selCount = (addr == SWT_ADDR_COUNT);
  assign selState = (addr == SWT_ADDR_STATE);

  // Write strobes per register
  assign wrReload = wrEn && selReload;
  assign wrCtrl = wrEn && selCtrl;
  assign wrStatus = wrEn && selStatus;
  assign wrMask = wrEn && selMask;
  assign wrIntEn = wrEn && selIntEn;

  // Start request: run bit written from 0 to 1
  assign startRun = wrCtrl && wrData[SWT_CTRL_RUN_BIT] && !run_q;

  // Counting ignores lowPowerMode entirely so it goes on while asleep
  assign rollover = run_q && step && (count_q == CNT_WIDTH'(SWT_COUNT_TOP));

  // Counter: reload at start and at rollover, else increment on step
  always_comb begin
    count_d = count_q;
    if (startRun) begin
      count_d = CNT_WIDTH'(reload_q);
    end else if (rollover) begin
      count_d = CNT_WIDTH'(reload_q);
    end else if (run_q && step) begin
      count_d = count_q + 1'b1;
    end
  end

  // Overflow flag: hardware only sets, a written zero clears, set wins
  always_comb begin
    overflowFlag_d = overflowFlag_q;
    if (wrCtrl && !wrData[SWT_CTRL_FLAG_BIT]) begin
      overflowFlag_d = 1'b0;
    end
    if (rollover) begin
      overflowFlag_d = 1'b1;
    end
  end

  // Event sources and write-one-to-clear, set beats clear
  assign evtSet[SWT_EVT_OVERFLOW] = rollover;
  assign evtSet[SWT_EVT_UNSTABLE_START] = startRun && !stableSync;
  assign evtClr = wrStatus ? wrData[SWT_EVT_NUM-1:0] : '0;
  assign evtStatus_d = (evtStatus_q & ~evtClr) | evtSet;

  // Next control, reload, mask and enable values from the write strobes
  assign run_d = wrCtrl ? wrData[SWT_CTRL_RUN_BIT] : run_q;
  assign prescale_d = wrCtrl ? wrData[SWT_CTRL_PS_MSB:SWT_CTRL_PS_LSB] : prescale_q;
  assign reload_d = wrReload ? wrData : reload_q;
  assign evtMask_d = wrMask ? wrData[SWT_EVT_NUM-1:0] : evtMask_q;
  assign wakeIntEn_d = wrIntEn ? wrData[SWT_INTEN_WAKE_BIT] : wakeIntEn_q;

  // Counter register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= CNT_WIDTH'(SWT_COUNT_RST);
    end else begin
      count_q <= count_d;
    end
  end

  // Overflow flag register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      overflowFlag_q <= 1'b0;
    end else begin
      overflowFlag_q <= overflowFlag_d;
    end
  end

  // Sticky event status register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      evtStatus_q <= '0;
    end else begin
      evtStatus_q <= evtStatus_d;
    end
  end

  // Run bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_q <= SWT_CTRL_RST[SWT_CTRL_RUN_BIT];
    end else begin
      run_q <= run_d;
    end
  end

  // Prescale select
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prescale_q <= SWT_PS_RST;
    end else begin
      prescale_q <= prescale_d;
    end
  end

  // Reload register; a write while running takes effect at next reload
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reload_q <= SWT_RELOAD_RST;
    end else begin
      reload_q <= reload_d;
    end
  end

  // Event mask
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      evtMask_q <= '0;
    end else begin
      evtMask_q <= evtMask_d;
    end
  end

  // Timer interrupt enable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wakeIntEn_q <= 1'b0;
    end else begin
      wakeIntEn_q <= wakeIntEn_d;
    end
  end

  // Read views of control and state
  assign ctrlView = {3'h0, overflowFlag_q, run_q, prescale_q};
  assign stateView = {6'h00, run_q, stableSync};

  // Read multiplexer; unmapped addresses read zero
  assign rdMux = selReload ? reload_q :
                 selCtrl ? ctrlView :
                 selStatus ? 8'(evtStatus_q) :
                 selMask ? 8'(evtMask_q) :
                 selIntEn ? {7'h00, wakeIntEn_q} :
                 selCount ? 8'(count_q) :
                 selState ? stateView : 8'h00;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdData_q <= 8'h00;
    end else begin
      rdData_q <= rdEn ? rdMux : 8'h00;
    end
  end

  assign rdData = rdData_q;

  // Wake pulse to the power manager on every rollover
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wakeupEvent_q <= 1'b0;
    end else begin
      wakeupEvent_q <= rollover;
    end
  end

  assign wakeupEvent = wakeupEvent_q;

  // Oscillator held on through low power while the timer runs
  assign lircKeepOn = run_q && lowPowerMode;

  // Timer interrupt request from flag and both enables
  assign wakeupIrqReq = overflowFlag_q && wakeIntEn_q && globalIntEnable;

  // Level interrupt from unmasked sticky events
  assign irq = |(evtStatus_q & evtMask_q);

endmodule // swt_top

// File: dv/swt_top_props.sv
// Port assertions for the wake-up timer
`timescale 1ns/1ns
module swt_top_props
  import swt_pkg::*;
#(
  parameter int CNT_WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [7:0] rdData,
  // Oscillator, power, interrupts
  input wire logic lircClk,
  input wire logic lircStable,
  input wire logic lowPowerMode,
  input wire logic globalIntEnable,
  input wire logic lircKeepOn,
  input wire logic wakeupEvent,
  input wire logic wakeupIrqReq,
  input wire logic irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Register accesses
  wire logic wrRel = wrEn && addr == SWT_ADDR_RELOAD;
  wire logic wrCtl = wrEn && addr == SWT_ADDR_CTRL;
  wire logic rdRel = rdEn && addr == SWT_ADDR_RELOAD;
  wire logic rdCtl = rdEn && addr == SWT_ADDR_CTRL;
  // Output relations
  chk_keep_power: assert property (lircKeepOn |-> lowPowerMode)
    else $error("keep-on when awake");
  chk_keep_event: assert property (wakeupEvent && lowPowerMode |-> lircKeepOn)
    else $error("oscillator released");
  chk_irq_gate: assert property (!globalIntEnable |-> !wakeupIrqReq)
    else $error("request while disabled");
  chk_flag_hold: assert property (
    $past(wakeupIrqReq) && globalIntEnable && !$past(wrEn) |-> wakeupIrqReq)
    else $error("flag dropped");
  chk_evt_pulse: assert property (wakeupEvent |=> !wakeupEvent)
    else $error("event too long");
  chk_rd_idle: assert property (!$past(rdEn) |-> rdData == 8'h00)
    else $error("stray read data");
  chk_reload_echo: assert property (
    wrRel ##1 rdRel |=> rdData == $past(wrData, 2))
    else $error("reload read-back");
  chk_ctrl_echo: assert property (
    wrCtl ##1 rdCtl |=> (rdData & 8'hEF) == ($past(wrData, 2) & 8'h0F))
    else $error("control read-back");
  // Main scenarios
  cover property (wakeupEvent && lowPowerMode);
  cover property (irq && wakeupIrqReq);
  cover property (wrRel ##1 rdRel);
endmodule // swt_top_props

bind swt_top swt_top_props #(.CNT_WIDTH(CNT_WIDTH)) swt_top_props_inst (.clk(clk),
  .rstn(rstn), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
  .lircClk(lircClk), .lircStable(lircStable), .lowPowerMode(lowPowerMode),
  .globalIntEnable(globalIntEnable), .lircKeepOn(lircKeepOn), .wakeupEvent(wakeupEvent),
  .wakeupIrqReq(wakeupIrqReq), .irq(irq));

// File: dv/tb.sv
// Self-checking bench for the wake-up timer
`timescale 1ns/1ns
module tb
  import swt_pkg::*;
;
  // Driven and observed signals
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wrData = 8'h00;
  logic wrEn = 1'b0;
  logic rdEn = 1'b0;
  logic lircClk = 1'b0;
  logic lircStable = 1'b1;
  logic lowPowerMode = 1'b0;
  logic globalIntEnable = 1'b0;
  logic [7:0] rdData;
  logic lircKeepOn;
  logic wakeupEvent;
  logic wakeupIrqReq;
  logic irq;
  // Bookkeeping
  int failures = 0;
  int total_checks = 0;
  int shf[8] = '{0, 2, 4, 6, 8, 9, 10, 11};
  logic [7:0] expQ[$];
  logic rdPend = 1'b0;
  logic msk = 1'b0;
  logic [7:0] rnd;

  // Clock
  always #4 clk = ~clk;

  // Device under test
  swt_top swt_top_inst (.clk(clk), .rstn(rstn), .addr(addr), .wrData(wrData),
    .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .lircClk(lircClk),
    .lircStable(lircStable), .lowPowerMode(lowPowerMode),
    .globalIntEnable(globalIntEnable), .lircKeepOn(lircKeepOn),
    .wakeupEvent(wakeupEvent), .wakeupIrqReq(wakeupIrqReq), .irq(irq));

  // Compare and count
  task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // Compare one output flag
  task automatic cmpBit(string what, logic exp, logic got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One-cycle register write
  task automatic wr(logic [7:0] a, logic [7:0] d);
    if (wrEn) @(posedge clk);
    wrEn <= 1'b1;
    addr <= a;
    wrData <= d;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask

  // One-cycle register read, expectation queued
  task automatic rd(logic [7:0] a, logic [7:0] e);
    if (rdEn) @(posedge clk);
    rdEn <= 1'b1;
    addr <= a;
    expQ.push_back(e);
    @(posedge clk);
    rdEn <= 1'b0;
  endtask

  // Read data monitor
  always @(posedge clk) begin
    if (rdPend) cmp("rdData", 16'(expQ.pop_front()), 16'(rdData));
    rdPend <= rdEn;
  end

  // Run from a reload value, count oscillator ticks up to the rollover
  task automatic measure(logic [2:0] ps, logic [7:0] rl, int exp, logic lp);
    int ticks;
    int i;
    ticks = 0;
    wr(SWT_ADDR_RELOAD, rl);
    wr(SWT_ADDR_CTRL, {5'h01, ps});
    lowPowerMode <= lp;
    for (i = 0; i < exp * 8 + 64; i++) begin
      lircClk <= i[2];
      if (i % 8 == 4) ticks++;
      @(posedge clk);
      if (wakeupEvent === 1'b1) break;
    end
    if (i == exp * 8 + 64) begin
      failures++;
      conclude();
    end
    lircClk <= 1'b0;
    cmp("ticks", 16'(exp), 16'(ticks));
    cmpBit("irq", msk, irq);
    cmpBit("irqReq", globalIntEnable, wakeupIrqReq);
    cmpBit("keepOn", lp, lircKeepOn);
    rd(SWT_ADDR_COUNT, rl);
    rd(SWT_ADDR_CTRL, {3'h0, 2'h3, ps});
    rd(SWT_ADDR_EVT_STATUS, 8'h01);
    wr(SWT_ADDR_CTRL, 8'h00);
    wr(SWT_ADDR_EVT_STATUS, 8'h01);
    @(posedge clk);
    cmpBit("irqReq", 1'b0, wakeupIrqReq);
    cmpBit("irq", 1'b0, irq);
    cmpBit("keepOn", 1'b0, lircKeepOn);
    lowPowerMode <= 1'b0;
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'hdc69853b));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(SWT_ADDR_RELOAD, SWT_RELOAD_RST);
    rd(SWT_ADDR_CTRL, SWT_CTRL_RST);
    rnd = 8'($urandom);
    wr(8'h20, rnd);
    rd(8'h20, 8'h00);
    wr(SWT_ADDR_RELOAD, rnd);
    rd(SWT_ADDR_RELOAD, rnd);
    wr(SWT_ADDR_CTRL, rnd & 8'h07 | 8'h10);
    rd(SWT_ADDR_CTRL, rnd & 8'h07);
    wr(SWT_ADDR_INT_EN, 8'h01);
    for (int k = 0; k < 8; k++) begin
      globalIntEnable <= k[0];
      msk = ~k[1];
      wr(SWT_ADDR_EVT_MASK, {7'h00, msk});
      measure(k[2:0], k == 0 ? 8'hFE : 8'hFF, k == 0 ? 2 : 1 << shf[k], k[2]);
    end
    // Start while the oscillator is not yet stable
    lircStable <= 1'b0;
    repeat (3) @(posedge clk);
    wr(SWT_ADDR_EVT_MASK, 8'h02);
    rd(SWT_ADDR_STATE, 8'h00);
    wr(SWT_ADDR_CTRL, 8'h08);
    rd(SWT_ADDR_EVT_STATUS, 8'h02);
    cmpBit("irq", 1'b1, irq);
    rd(SWT_ADDR_STATE, 8'h02);
    wr(SWT_ADDR_CTRL, 8'h00);
    wr(SWT_ADDR_EVT_STATUS, 8'h02);
    lircStable <= 1'b1;
    @(posedge clk);
    cmpBit("irq", 1'b0, irq);
    conclude();
  end
endmodule // tb
